/* hdl/rsp_ref_select.sv */
// reference selection, pre-scalers, feedback settings and output bank dividers
`timescale 1ns/100ps
// How it works
// - primary-select bit 0 picks crystal/reference input, 1 picks auxiliary clock input
// - the non-primary input serves as secondary backup reference
// - select pin low routes primary to the plls, high routes secondary
// - select pin is ignored in manual frequency control mode 2
// - load capacitance is 3.5 pF plus code times 0.125 pF
// - each pll pre-scaler divides the selected reference by 1 to 255
// - pre-scaler zero powers down that pll and its output banks
// - pll0/1 feedback is 2N plus adjust plus one, adjust 0000 counts -1
// - with spread enabled pll0/1 feedback gains offset/64 fraction
// - pll2 feedback is its 12-bit integer only, no fraction
// - banks two to six divide by 2, bank one passes undivided
// - reprogramming dividers while running may glitch outputs
// - feedback integer zero drives the oscillator to minimum frequency
module rsp_ref_select
   import rsp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic crystal_or_ref_in_i,
   input wire logic aux_clock_in_i,
   input wire logic general_input_five_i,
   input wire logic [1:0] manual_freq_control_i,
   input wire logic [5:0] bank_post_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic ref_src_o,
   output logic [2:0] ref_div_pulse_o,
   output logic [2:0] pll_pd_o,
   output logic [2:0] vco_min_o,
   output logic [2:0][13:0] fb_int_o,
   output logic [1:0][5:0] fb_frac_o,
   output logic [8:0] load_cap_o,
   output logic [1:0] crystal_drive_strength_o,
   output logic [5:0] bank_out_o
);
   typedef struct packed {
      logic [1:0] ref_s1;
      logic [1:0] ref_s2;
      logic sel_s1;
      logic sel_s2;
      logic [1:0] mfc_s1;
      logic [1:0] mfc_s2;
      logic [5:0] bank_s1;
      logic [5:0] bank_s2;
      logic [5:0] bank_prev;
      logic ref_prev;
      logic ref_src;
      logic [7:0] crystal_drive_cfg;
      logic [7:0] xcap;
      logic [7:0] rsel;
      logic [1:0][7:0] ssoff;
      logic [2:0][7:0] pre;
      logic [2:0][7:0] nlo;
      logic [2:0][7:0] nhi;
      logic [1:0][7:0] adj;
      logic [7:0] ssen;
      logic [1:0][7:0] bmap;
      logic [2:0][7:0] cnt;
      logic [2:0] pulse;
      logic [2:0][13:0] fb_int;
      logic [1:0][5:0] fb_frac;
      logic [8:0] load_cap;
      logic [5:0] bank_q;
      logic [7:0] rdata;
   } rsp_state_type;

   rsp_state_type state_r;
   rsp_state_type state_nxt;
   logic pin_eff;
   logic prim_val;
   logic sec_val;
   logic ref_edge;
   logic [2:0] pd;
   logic [1:0] bsrc;

   assign pd = {state_r.pre[2] == 8'h00, state_r.pre[1] == 8'h00, state_r.pre[0] == 8'h00};
   // pin ignored in mfc mode 2
   assign pin_eff = state_r.sel_s2 && (state_r.mfc_s2 != MFC_NO_PIN);
   assign prim_val = state_r.rsel[PRIM_SEL_BIT] ? state_r.ref_s2[1] : state_r.ref_s2[0];
   // the other input is the secondary
   assign sec_val = state_r.rsel[PRIM_SEL_BIT] ? state_r.ref_s2[0] : state_r.ref_s2[1];

   always_comb begin
      logic sel_val;
      logic [8:0] cnt_inc;
      logic [13:0] adj_term;
      sel_val = 1'b0;
      cnt_inc = 9'h000;
      adj_term = 14'h0000;
      bsrc = 2'h0;
      state_nxt = state_r;
      state_nxt.ref_s1 = {aux_clock_in_i, crystal_or_ref_in_i};
      state_nxt.ref_s2 = state_r.ref_s1;
      state_nxt.sel_s1 = general_input_five_i;
      state_nxt.sel_s2 = state_r.sel_s1;
      state_nxt.mfc_s1 = manual_freq_control_i;
      state_nxt.mfc_s2 = state_r.mfc_s1;
      state_nxt.bank_s1 = bank_post_i;
      state_nxt.bank_s2 = state_r.bank_s1;
      state_nxt.bank_prev = state_r.bank_s2;
      // pin low gives primary, high gives secondary
      sel_val = pin_eff ? sec_val : prim_val;
      state_nxt.ref_src = pin_eff ^ state_r.rsel[PRIM_SEL_BIT];
      // a source switch may look like an edge; tolerated like any reprogramming glitch
      state_nxt.ref_prev = sel_val;
      ref_edge = sel_val && !state_r.ref_prev;
      for (int k = 0; k < 3; k++) begin
         // divide selected reference by pre-scaler value
         state_nxt.pulse[k] = 1'b0;
         cnt_inc = {1'b0, state_r.cnt[k]} + 9'h001;
         if (pd[k]) begin
            // zero pre-scaler stops the divided reference
            state_nxt.cnt[k] = 8'h00;
         end else if (ref_edge) begin
            // new divisor is compared against the running count from the next reference edge
            if (cnt_inc >= {1'b0, state_r.pre[k]}) begin
               state_nxt.cnt[k] = 8'h00;
               state_nxt.pulse[k] = 1'b1;
            end else begin
               state_nxt.cnt[k] = cnt_inc[7:0];
            end
         end
      end
      for (int k = 0; k < 2; k++) begin
         // adjust 0000 means -1, which cancels the +1
         adj_term = (state_r.adj[k][3:0] == 4'h0) ? 14'h0000 : {10'h000, state_r.adj[k][3:0]} + 14'h0001;
         state_nxt.fb_int[k] = {1'b0, state_r.nhi[k][3:0], state_r.nlo[k], 1'b0} + adj_term;
         // spread offset becomes the fraction in 1/64 steps
         state_nxt.fb_frac[k] = state_r.ssen[k] ? state_r.ssoff[k][5:0] : 6'h00;
      end
      // pll2 uses the integer field only
      state_nxt.fb_int[2] = {2'h0, state_r.nhi[2][3:0], state_r.nlo[2]};
      // load in 0.125 pF steps above the 3.5 pF base
      state_nxt.load_cap = LOAD_BASE_STEPS + {1'b0, state_r.xcap};
      for (int b = 0; b < 6; b++) begin
         bsrc = state_r.bmap[b / 4][(b % 4) * 2 +: 2];
         if (bsrc == 2'h3) begin
            bsrc = 2'h2;
         end
         if (pd[bsrc]) begin
            // banks of a powered-down pll stay low
            state_nxt.bank_q[b] = 1'b0;
         end else if (b == 0) begin
            // bank one has no post division
            state_nxt.bank_q[b] = state_r.bank_s2[b];
         end else if (state_r.bank_s2[b] && !state_r.bank_prev[b]) begin
            // fixed divide by 2 on banks two to six
            state_nxt.bank_q[b] = !state_r.bank_q[b];
         end
      end
      // writes land immediately with no glitch-free handover
      if (reg_wr_i) begin
         case (reg_addr_i)
            OFS_XTAL_DRIVE: state_nxt.crystal_drive_cfg = reg_wdata_i;
            OFS_XTAL_LOAD: state_nxt.xcap = reg_wdata_i;
            OFS_REF_SEL: state_nxt.rsel = reg_wdata_i;
            OFS_PRESCALE0: state_nxt.pre[0] = reg_wdata_i;
            OFS_PRESCALE0 + 8'h01: state_nxt.pre[1] = reg_wdata_i;
            OFS_PRESCALE0 + 8'h02: state_nxt.pre[2] = reg_wdata_i;
            OFS_FB_INT_LO0: state_nxt.nlo[0] = reg_wdata_i;
            OFS_FB_INT_LO0 + 8'h01: state_nxt.nlo[1] = reg_wdata_i;
            OFS_FB_INT_LO0 + 8'h02: state_nxt.nlo[2] = reg_wdata_i;
            OFS_FB_INT_HI0: state_nxt.nhi[0] = {4'h0, reg_wdata_i[3:0]};
            OFS_FB_INT_HI0 + 8'h01: state_nxt.nhi[1] = {4'h0, reg_wdata_i[3:0]};
            OFS_FB_INT_HI0 + 8'h02: state_nxt.nhi[2] = {4'h0, reg_wdata_i[3:0]};
            OFS_FB_ADJ0: state_nxt.adj[0] = {4'h0, reg_wdata_i[3:0]};
            OFS_FB_ADJ0 + 8'h01: state_nxt.adj[1] = {4'h0, reg_wdata_i[3:0]};
            OFS_SPREAD_EN: state_nxt.ssen = {6'h00, reg_wdata_i[1:0]};
            OFS_BANK_MAP0: state_nxt.bmap[0] = reg_wdata_i;
            OFS_BANK_MAP0 + 8'h01: state_nxt.bmap[1] = {4'h0, reg_wdata_i[3:0]};
            OFS_SS_OFFSET0: state_nxt.ssoff[0] = {2'h0, reg_wdata_i[5:0]};
            OFS_SS_OFFSET1: state_nxt.ssoff[1] = {2'h0, reg_wdata_i[5:0]};
            default: ;
         endcase
      end
      state_nxt.rdata = 8'h00;
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_XTAL_DRIVE: state_nxt.rdata = state_r.crystal_drive_cfg;
            OFS_XTAL_LOAD: state_nxt.rdata = state_r.xcap;
            OFS_REF_SEL: state_nxt.rdata = state_r.rsel;
            OFS_PRESCALE0: state_nxt.rdata = state_r.pre[0];
            OFS_PRESCALE0 + 8'h01: state_nxt.rdata = state_r.pre[1];
            OFS_PRESCALE0 + 8'h02: state_nxt.rdata = state_r.pre[2];
            OFS_FB_INT_LO0: state_nxt.rdata = state_r.nlo[0];
            OFS_FB_INT_LO0 + 8'h01: state_nxt.rdata = state_r.nlo[1];
            OFS_FB_INT_LO0 + 8'h02: state_nxt.rdata = state_r.nlo[2];
            OFS_FB_INT_HI0: state_nxt.rdata = state_r.nhi[0];
            OFS_FB_INT_HI0 + 8'h01: state_nxt.rdata = state_r.nhi[1];
            OFS_FB_INT_HI0 + 8'h02: state_nxt.rdata = state_r.nhi[2];
            OFS_FB_ADJ0: state_nxt.rdata = state_r.adj[0];
            OFS_FB_ADJ0 + 8'h01: state_nxt.rdata = state_r.adj[1];
            OFS_SPREAD_EN: state_nxt.rdata = state_r.ssen;
            OFS_BANK_MAP0: state_nxt.rdata = state_r.bmap[0];
            OFS_BANK_MAP0 + 8'h01: state_nxt.rdata = state_r.bmap[1];
            OFS_STATUS: state_nxt.rdata = {1'b0, vco_min_o, pd, state_r.ref_src};
            OFS_SS_OFFSET0: state_nxt.rdata = state_r.ssoff[0];
            OFS_SS_OFFSET1: state_nxt.rdata = state_r.ssoff[1];
            default: state_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= '0;
         state_r.crystal_drive_cfg <= RST_XTAL_DRIVE;
         state_r.xcap <= RST_XTAL_LOAD;
         state_r.rsel <= RST_REF_SEL;
         state_r.pre <= {RST_PRESCALE, RST_PRESCALE, RST_PRESCALE};
         state_r.nlo <= {RST_FB_INT_LO, RST_FB_INT_LO, RST_FB_INT_LO};
         state_r.adj <= {RST_ZERO, RST_ZERO};
         state_r.load_cap <= LOAD_BASE_STEPS;
         // feedback outputs start from the reset settings, so nothing reads a bogus zero divisor
         state_r.fb_int <= {{6'h00, RST_FB_INT_LO}, {5'h00, RST_FB_INT_LO, 1'b0}, {5'h00, RST_FB_INT_LO, 1'b0}};
      end else begin
         state_r <= state_nxt;
      end
   end

   // integer field zero flags minimum oscillator frequency
   assign vco_min_o = {state_r.nhi[2][3:0] == 4'h0 && state_r.nlo[2] == 8'h00,
                       state_r.nhi[1][3:0] == 4'h0 && state_r.nlo[1] == 8'h00,
                       state_r.nhi[0][3:0] == 4'h0 && state_r.nlo[0] == 8'h00};
   assign pll_pd_o = pd;
   assign reg_rdata_o = state_r.rdata;
   assign ref_src_o = state_r.ref_src;
   assign ref_div_pulse_o = state_r.pulse;
   assign fb_int_o = state_r.fb_int;
   assign fb_frac_o = state_r.fb_frac;
   assign load_cap_o = state_r.load_cap;
   assign crystal_drive_strength_o = state_r.crystal_drive_cfg[1:0];
   assign bank_out_o = state_r.bank_q;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_src_primary: assert property ((!pin_eff && !state_r.rsel[0]) |=> !ref_src_o)
      else $error("primary not routed");
   a_src_second: assert property ((pin_eff && !state_r.rsel[0]) |=> ref_src_o)
      else $error("secondary not routed");
   a_mfc_block: assert property ((state_r.mfc_s2 == MFC_NO_PIN && state_r.rsel[0]) |=> ref_src_o)
      else $error("pin acted in mfc mode 2");
   a_load_cap: assert property ((reg_wr_i && reg_addr_i == OFS_XTAL_LOAD)
      |-> ##2 load_cap_o == LOAD_BASE_STEPS + {1'b0, $past(reg_wdata_i, 2)})
      else $error("load capacitance wrong");
   a_pre_one: assert property ((state_r.pre[1] == 8'h01 && ref_edge) |=> ref_div_pulse_o[1])
      else $error("divide by one missed edge");
   a_pd_quiet: assert property ((pll_pd_o[0] && $past(pll_pd_o[0])) |-> !ref_div_pulse_o[0])
      else $error("powered-down pll pulsed");
   a_adj_minus: assert property ((state_r.adj[0][3:0] == 4'h0)
      |=> fb_int_o[0] == {1'b0, $past(state_r.nhi[0][3:0]), $past(state_r.nlo[0]), 1'b0})
      else $error("adjust zero not -1");
   a_frac_off: assert property (!state_r.ssen[1] |=> fb_frac_o[1] == 6'h00)
      else $error("fraction without spread");
   a_pll2_int: assert property (##1 fb_int_o[2] == {2'h0, $past(state_r.nhi[2][3:0]), $past(state_r.nlo[2])})
      else $error("pll2 feedback wrong");
   a_bank_div: assert property ((state_r.bank_s2[1] && !state_r.bank_prev[1] && !pd[state_r.bmap[0][3:2] == 2'h3 ? 2'h2 : state_r.bmap[0][3:2]])
      |=> bank_out_o[1] != $past(bank_out_o[1]))
      else $error("bank two did not toggle");

   c_switch: cover property (ref_src_o ##1 !ref_src_o);
   c_pulse: cover property (ref_div_pulse_o[2]);
   c_pd: cover property (pll_pd_o[0]);
endmodule : rsp_ref_select

/* include/rsp_pkg.sv */
// constants for the reference select and pll divider configuration block
package rsp_pkg;
   // register offsets
   localparam logic [7:0] OFS_XTAL_DRIVE = 8'h06;
   localparam logic [7:0] OFS_XTAL_LOAD = 8'h07;
   localparam logic [7:0] OFS_REF_SEL = 8'h34;
   localparam logic [7:0] OFS_PRESCALE0 = 8'h40;
   localparam logic [7:0] OFS_FB_INT_LO0 = 8'h44;
   localparam logic [7:0] OFS_FB_INT_HI0 = 8'h48;
   localparam logic [7:0] OFS_FB_ADJ0 = 8'h4c;
   localparam logic [7:0] OFS_SPREAD_EN = 8'h4e;
   localparam logic [7:0] OFS_BANK_MAP0 = 8'h50;
   localparam logic [7:0] OFS_STATUS = 8'h5f;
   localparam logic [7:0] OFS_SS_OFFSET0 = 8'h61;
   localparam logic [7:0] OFS_SS_OFFSET1 = 8'h69;
   // field positions
   localparam int PRIM_SEL_BIT = 0;
   localparam int SW_MODE_LSB = 1;
   // reset values
   localparam logic [7:0] RST_XTAL_DRIVE = 8'h03;
   localparam logic [7:0] RST_XTAL_LOAD = 8'h00;
   localparam logic [7:0] RST_REF_SEL = 8'h00;
   localparam logic [7:0] RST_PRESCALE = 8'h01;
   localparam logic [7:0] RST_FB_INT_LO = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // 3.5 pF base expressed in 0.125 pF steps
   localparam logic [8:0] LOAD_BASE_STEPS = 9'h01c;
   // manual frequency control mode in which the select pin is ignored
   localparam logic [1:0] MFC_NO_PIN = 2'h2;
endpackage : rsp_pkg

/* tb/rsp_ref_src_model.sv */
// behavioural crystal and auxiliary reference sources
`timescale 1ns/100ps
module rsp_ref_src_model #(
   parameter int XTAL_HALF_NS = 40,
   parameter int AUX_HALF_NS = 70
) (
   input wire logic xtal_en_i,
   input wire logic aux_en_i,
   output logic crystal_o,
   output logic aux_o
);
   // whole periods only; a stopped source rests low like a gated oscillator
   initial begin
      crystal_o = 1'b0;
      forever begin
         wait (xtal_en_i);
         crystal_o <= 1'b1;
         #(XTAL_HALF_NS);
         crystal_o <= 1'b0;
         #(XTAL_HALF_NS);
      end
   end
   initial begin
      aux_o = 1'b0;
      forever begin
         wait (aux_en_i);
         aux_o <= 1'b1;
         #(AUX_HALF_NS);
         aux_o <= 1'b0;
         #(AUX_HALF_NS);
      end
   end
endmodule : rsp_ref_src_model

/* tb/rsp_ref_select_bench.sv */
// self-checking bench for reference select and divider configuration
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module rsp_ref_select_bench
   import rsp_pkg::*;
;
   logic ref_clk_i, rst_n_i, general_input_five, wr, rd, xen, aen, crystal, aux, ref_src;
   logic [1:0] manual_freq_control, drv;
   logic [5:0] bpost, bank;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] pulse, pd, vmin;
   logic [2:0][13:0] fb_int;
   logic [1:0][5:0] fb_frac;
   logic [8:0] load_cap;
   int n_errors = 0;
   int checks = 0;
   int pcnt [3];
   int c0, c1, c2;
   // {prim, pin, mfc, expected source}
   logic [4:0] tbl [8] = '{5'h00, 5'h09, 5'h11, 5'h18, 5'h0c, 5'h1d, 5'h0b, 5'h0f};
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      for (int k = 0; k < 3; k++) begin
         pcnt[k] <= pcnt[k] + int'(pulse[k]);
      end
   end
   rsp_ref_src_model rsp_ref_src_model_i (.xtal_en_i(xen), .aux_en_i(aen), .crystal_o(crystal), .aux_o(aux));
   rsp_ref_select rsp_ref_select_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .crystal_or_ref_in_i(crystal),
      .aux_clock_in_i(aux), .general_input_five_i(general_input_five), .manual_freq_control_i(manual_freq_control), .bank_post_i(bpost),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .ref_src_o(ref_src), .ref_div_pulse_o(pulse), .pll_pd_o(pd), .vco_min_o(vmin), .fb_int_o(fb_int),
      .fb_frac_o(fb_frac), .load_cap_o(load_cap), .crystal_drive_strength_o(drv), .bank_out_o(bank));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr <= 1'b0;
      cyc(2);
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask : rd_chk
   // a burst is whole crystal periods, so the edge count is exact
   task automatic burst(input int n);
      @(posedge ref_clk_i);
      xen <= 1'b1;
      repeat (n) @(posedge crystal);
      xen <= 1'b0;
      cyc(20);
   endtask : burst
   task automatic t_reset;
      rd_chk(OFS_XTAL_DRIVE, 8'h03);
      rd_chk(OFS_XTAL_LOAD, 8'h00);
      rd_chk(OFS_REF_SEL, 8'h00);
      rd_chk(8'h00, 8'h00);
      `CHK("drive", 2'h3, drv)
      `CHK("load", 9'h01c, load_cap)
      `CHK("fb0", 14'h0002, fb_int[0])
      `CHK("fb2", 14'h0001, fb_int[2])
      $display("test reset done");
   endtask : t_reset
   task automatic t_load;
      wr_reg(OFS_XTAL_LOAD, 8'hff);
      `CHK("load", 9'h11b, load_cap)
      rd_chk(OFS_XTAL_LOAD, 8'hff);
      wr_reg(OFS_XTAL_LOAD, 8'h00);
      wr_reg(OFS_XTAL_DRIVE, 8'h03);
      `CHK("load", 9'h01c, load_cap)
      $display("test load done");
   endtask : t_load
   task automatic t_fb;
      wr_reg(OFS_FB_INT_LO0, 8'h16);
      wr_reg(OFS_FB_ADJ0, 8'h03);
      `CHK("fb0", 14'h0030, fb_int[0])
      wr_reg(OFS_FB_ADJ0, 8'h00);
      `CHK("fb0", 14'h002c, fb_int[0])
      wr_reg(OFS_FB_INT_LO0 + 8'h02, 8'hff);
      wr_reg(OFS_FB_INT_HI0 + 8'h02, 8'hff);
      `CHK("fb2", 14'h0fff, fb_int[2])
      rd_chk(OFS_FB_INT_HI0 + 8'h02, 8'h0f);
      `CHK("vmin", 3'h0, vmin)
      wr_reg(OFS_FB_INT_LO0 + 8'h01, 8'h00);
      `CHK("vmin", 3'h2, vmin)
      wr_reg(OFS_FB_INT_LO0 + 8'h01, 8'h01);
      `CHK("fb1", 14'h0002, fb_int[1])
      $display("test feedback done");
   endtask : t_fb
   task automatic t_spread;
      wr_reg(OFS_SS_OFFSET0, 8'h05);
      `CHK("frac0", 6'h00, fb_frac[0])
      wr_reg(OFS_SPREAD_EN, 8'h01);
      `CHK("frac0", 6'h05, fb_frac[0])
      wr_reg(OFS_SS_OFFSET1, 8'h3f);
      wr_reg(OFS_SPREAD_EN, 8'h03);
      `CHK("frac1", 6'h3f, fb_frac[1])
      $display("test spread done");
   endtask : t_spread
   task automatic t_sel;
      // pin, primary bit and mfc mode all stepped per table entry; switch mode left at manual
      for (int i = 0; i < 8; i++) begin
         wr_reg(OFS_REF_SEL, {7'h00, tbl[i][4]});
         @(posedge ref_clk_i);
         general_input_five <= tbl[i][3];
         manual_freq_control <= tbl[i][2:1];
         cyc(6);
         `CHK("ref_src", tbl[i][0], ref_src)
      end
      wr_reg(OFS_REF_SEL, 8'h00);
      general_input_five <= 1'b0;
      manual_freq_control <= 2'h0;
      $display("test select done");
   endtask : t_sel
   task automatic t_pulse;
      wr_reg(OFS_PRESCALE0, 8'h03);
      burst(6);
      c0 = pcnt[0];
      c1 = pcnt[1];
      c2 = pcnt[2];
      burst(12);
      `CHK("pulses0", 4, pcnt[0] - c0)
      `CHK("pulses1", 12, pcnt[1] - c1)
      `CHK("pulses2", 12, pcnt[2] - c2)
      @(posedge ref_clk_i);
      general_input_five <= 1'b1;
      cyc(6);
      c1 = pcnt[1];
      burst(6);
      `CHK("pulses1", 0, pcnt[1] - c1)
      // pin high now routes the auxiliary input as secondary
      c1 = pcnt[1];
      @(posedge ref_clk_i);
      aen <= 1'b1;
      repeat (5) @(posedge aux);
      aen <= 1'b0;
      cyc(20);
      `CHK("pulses1", 5, pcnt[1] - c1)
      general_input_five <= 1'b0;
      cyc(6);
      $display("test prescale done");
   endtask : t_pulse
   task automatic t_bank;
      wr_reg(OFS_BANK_MAP0 + 8'h01, 8'h0c);
      for (int i = 0; i < 3; i++) begin
         bpost <= 6'h3f;
         cyc(4);
         `CHK("bank1", 1'b1, bank[0])
         bpost <= 6'h00;
         cyc(4);
      end
      `CHK("banks", 6'h3e, bank)
      wr_reg(OFS_PRESCALE0, 8'h00);
      `CHK("pd", 3'h1, pd)
      `CHK("banks", 6'h20, bank)
      c0 = pcnt[0];
      burst(6);
      `CHK("pulses0", 0, pcnt[0] - c0)
      $display("test bank done");
   endtask : t_bank
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      {rst_n_i, general_input_five, wr, rd, xen, aen, manual_freq_control, bpost, addr, wdata} = '0;
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      cyc(2);
      t_reset;
      t_load;
      t_fb;
      t_spread;
      t_sel;
      t_pulse;
      t_bank;
      end_sim;
   end
   // whole run is under a thousand cycles; this cuts a hang short
   initial begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      end_sim;
   end
endmodule : rsp_ref_select_bench
